// File: design/adcc_conv_ctrl.sv
// Functional notes
// - Channel field picks input zero to three.
// - Per-bit period from 2, 8, 32 Tosc or RC.
// - Setting go starts conversion of selected channel.
// - Done loads result, clears go, sets flag.
// - Converter powered only while enable bit set.
// - Port field decodes analog pins and reference.
// - Unimplemented control bits read as zero.
// - Result register untouched by reset.
// - Conversion lasts nine and a half periods.
// - Sampling capacitor disconnected when conversion starts.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
module adcc_conv_ctrl
	import adcc_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rstn,
	// Avalon-MM slave, word addressed
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	// Analog front end
	input  wire logic        i_cmp,
	output logic [7:0]       o_dac_code,
	output logic             o_sample_connect,
	output logic             o_power_on,
	output logic [1:0]       o_channel,
	output adcc_pin_s        o_pin_cfg,
	output logic             o_irq
);

	adcc_state_s st_r;
	adcc_state_s st_nxt;
	logic        half_tick;
	logic        acc_req;
	logic        acc_do;
	logic        wr_lane0;
	logic [7:0]  wd;
	logic        done_evt;
	logic        go_wr;

	// Port field decode: all-analog, pin 2 digital, pin 3 as external reference, or all digital
	function automatic adcc_pin_s pin_map(input logic [2:0] cfg);
		adcc_pin_s p;
		p.ext_ref = 1'b0;
		p.analog  = 4'hF;
		if (cfg[2:1] == PCFG_ALL_DIG) begin
			p.analog = 4'h0;
		end else begin
			p.ext_ref = cfg[0];
			if (cfg[2]) begin
				p.analog[2] = 1'b0;
			end
			if (cfg[0]) begin
				p.analog[3] = 1'b0;
			end
		end
		return p;
	endfunction

	// Byte image of converter_control_0; bit 1 always zero
	function automatic logic [7:0] ctrl0_img(input adcc_state_s s);
		logic [7:0] v;
		v = 8'h00;
		v[CTRL0_CS +: 2]  = s.clk_sel;
		v[CTRL0_CHS +: 3] = s.chan;
		v[CTRL0_GO]       = s.go;
		v[CTRL0_ON]       = s.on;
		return v;
	endfunction

	// Trial code of the successive approximation
	function automatic logic [7:0] trial(input logic [7:0] sar, input logic [7:0] mask);
		return sar | mask;
	endfunction

	// Per-bit clock source, run only during a conversion
	adcc_tad_gen u_tad (
		.i_ref_clk   (i_ref_clk),
		.i_rstn      (i_rstn),
		.i_run       (st_r.busy),
		.i_sel       (st_r.clk_sel),
		.o_half_tick (half_tick)
	);

	// Bus handshake: one wait cycle, then the transfer completes
	assign acc_req  = i_avs_read | i_avs_write;
	assign acc_do   = acc_req & ~st_r.wait_r;
	assign wr_lane0 = acc_do & i_avs_write & i_avs_byteenable[0];
	assign wd       = i_avs_writedata[7:0];
	assign go_wr    = wr_lane0 && (i_avs_address == REG_CTRL0);
	// An abort written in the final half period wins: no flag for a dropped result
	assign done_evt = st_r.busy && half_tick && (st_r.half_cnt == HALF_LAST)
		&& !(go_wr && (!wd[CTRL0_GO] || !wd[CTRL0_ON]));

	always_comb begin
		st_nxt = st_r;

		// Pin inputs pass two flops; only the second is read
		st_nxt.cmp_s1 = i_cmp;
		st_nxt.cmp_s2 = st_r.cmp_s1;

		// Wait drops one cycle after a request, then rises again
		st_nxt.wait_r = 1'b1;
		if (acc_req && st_r.wait_r) begin
			st_nxt.wait_r = 1'b0;
			st_nxt.rdata  = 32'h0000_0000;
			case (i_avs_address)
				REG_RESULT:   st_nxt.rdata[7:0] = st_r.result;
				REG_CTRL0:    st_nxt.rdata[7:0] = ctrl0_img(st_r);
				REG_PCFG:     st_nxt.rdata[2:0] = st_r.pcfg;
				REG_IRQ_STAT: st_nxt.rdata[IRQ_DONE] = st_r.done_st;
				REG_IRQ_MASK: st_nxt.rdata[IRQ_DONE] = st_r.done_msk;
				default:      st_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Register writes land at the edge after the wait has dropped, as waitrequest rises again
		if (wr_lane0) begin
			case (i_avs_address)
				REG_CTRL0: begin
					st_nxt.clk_sel = wd[CTRL0_CS +: 2];
					st_nxt.chan    = wd[CTRL0_CHS +: 3];
					st_nxt.on      = wd[CTRL0_ON];
					// Go only sticks if the converter was already on
					st_nxt.go      = wd[CTRL0_GO] & st_r.on;
				end
				REG_PCFG: begin
					st_nxt.pcfg = wd[2:0];
				end
				REG_IRQ_STAT: begin
					if (wd[IRQ_DONE]) begin
						st_nxt.done_st = 1'b0;
					end
				end
				REG_IRQ_MASK: begin
					st_nxt.done_msk = wd[IRQ_DONE];
				end
				default: begin
				end
			endcase
		end

		// Start on go rising while idle and powered
		if (!st_r.busy && st_nxt.go && st_nxt.on) begin
			st_nxt.busy        = 1'b1;
			st_nxt.sample_conn = 1'b0;
			st_nxt.half_cnt    = 5'h00;
			st_nxt.sar         = 8'h00;
			st_nxt.mask        = SAR_MSB;
			st_nxt.dac         = trial(8'h00, SAR_MSB);
		end else if (st_r.busy && (!st_nxt.go || !st_nxt.on)) begin
			// Clearing go or power aborts; result stays as it was
			st_nxt.busy        = 1'b0;
			st_nxt.go          = 1'b0;
			st_nxt.sample_conn = 1'b1;
		end else if (st_r.busy && half_tick) begin
			st_nxt.half_cnt = st_r.half_cnt + 5'h01;
			// One bit decided every full period, MSB first
			if (st_r.half_cnt[0] && st_r.half_cnt >= HALF_DECIDE_FIRST
				&& st_r.half_cnt <= HALF_DECIDE_LAST) begin
				if (st_r.cmp_s2) begin
					st_nxt.sar = trial(st_r.sar, st_r.mask);
				end
				st_nxt.mask = st_r.mask >> 1;
				st_nxt.dac  = trial(st_nxt.sar, st_nxt.mask);
			end
			if (st_r.half_cnt == HALF_LAST) begin
				st_nxt.result      = st_r.sar;
				st_nxt.go          = 1'b0;
				st_nxt.busy        = 1'b0;
				st_nxt.sample_conn = 1'b1;
			end
		end

		// Completion set wins over a same-cycle clear
		if (done_evt) begin
			st_nxt.done_st = 1'b1;
		end

		// Outputs are copies held in flops
		st_nxt.pin      = pin_map(st_nxt.pcfg);
		st_nxt.chan_out = st_nxt.chan[1:0];
		st_nxt.irq      = st_nxt.done_st & st_nxt.done_msk;
		if (!st_nxt.on) begin
			st_nxt.dac = 8'h00;
		end
	end

	// Reset clears control state but keeps the last result
	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r             <= '0;
			st_r.wait_r      <= 1'b1;
			st_r.sample_conn <= 1'b1;
			st_r.pin         <= pin_map(3'h0);
			st_r.result      <= st_r.result;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Power follows the enable bit directly
	assign o_power_on        = st_r.on;
	assign o_avs_readdata    = st_r.rdata;
	assign o_avs_waitrequest = st_r.wait_r;
	assign o_dac_code        = st_r.dac;
	assign o_sample_connect  = st_r.sample_conn;
	assign o_channel         = st_r.chan_out;
	assign o_pin_cfg         = st_r.pin;
	assign o_irq             = st_r.irq;

endmodule
`default_nettype wire

// File: shared/adcc_pkg.sv
package adcc_pkg;

	// Timing base: 20 MHz reference clock
	localparam int unsigned T_OSC_NS  = 50;
	// Nominal per-bit period of the internal RC source
	localparam int unsigned RC_TAD_NS = 4000;

	// Half per-bit periods, in reference cycles, per clock source
	localparam logic [6:0] HALF_2TOSC  = 7'h01;
	localparam logic [6:0] HALF_8TOSC  = 7'h04;
	localparam logic [6:0] HALF_32TOSC = 7'h10;
	localparam logic [6:0] HALF_RC     = 7'((RC_TAD_NS + 2 * T_OSC_NS - 1) / (2 * T_OSC_NS));

	// Conversion clock select codes
	localparam logic [1:0] CS_2TOSC  = 2'h0;
	localparam logic [1:0] CS_8TOSC  = 2'h1;
	localparam logic [1:0] CS_32TOSC = 2'h2;
	localparam logic [1:0] CS_RC     = 2'h3;

	// Register indices; byte address is four times the index
	localparam logic [7:0] REG_RESULT   = 8'h1E;
	localparam logic [7:0] REG_CTRL0    = 8'h1F;
	localparam logic [7:0] REG_PCFG     = 8'h9F;
	localparam logic [7:0] REG_IRQ_STAT = 8'hA0;
	localparam logic [7:0] REG_IRQ_MASK = 8'hA1;

	// Field positions inside converter_control_0
	localparam int unsigned CTRL0_ON  = 0;
	localparam int unsigned CTRL0_GO  = 2;
	localparam int unsigned CTRL0_CHS = 3;
	localparam int unsigned CTRL0_CS  = 6;
	localparam int unsigned IRQ_DONE  = 0;

	// Half-period sequence of one conversion: 19 halves make 9.5 periods
	localparam logic [4:0] HALF_DECIDE_FIRST = 5'h03;
	localparam logic [4:0] HALF_DECIDE_LAST  = 5'h11;
	localparam logic [4:0] HALF_LAST         = 5'h12;
	localparam logic [7:0] SAR_MSB           = 8'h80;

	// Port configuration codes that turn every pin digital
	localparam logic [1:0] PCFG_ALL_DIG = 2'h3;

	typedef struct packed {
		logic [3:0] analog;
		logic       ext_ref;
	} adcc_pin_s;

	typedef struct packed {
		logic [1:0]  clk_sel;
		logic [2:0]  chan;
		logic        go;
		logic        on;
		logic [2:0]  pcfg;
		logic [7:0]  result;
		logic        done_st;
		logic        done_msk;
		logic        irq;
		logic        busy;
		logic [4:0]  half_cnt;
		logic [7:0]  sar;
		logic [7:0]  mask;
		logic [7:0]  dac;
		logic        cmp_s1;
		logic        cmp_s2;
		logic        wait_r;
		logic [31:0] rdata;
		logic        sample_conn;
		adcc_pin_s   pin;
		logic [1:0]  chan_out;
	} adcc_state_s;

	typedef struct packed {
		logic [6:0] cnt;
		logic       tick;
	} adcc_tick_s;

endpackage

// File: design/adcc_tad_gen.sv
`timescale 1ns/100ps
`default_nettype none
module adcc_tad_gen
	import adcc_pkg::*;
(
	input  wire logic       i_ref_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_run,
	input  wire logic [1:0] i_sel,
	output logic            o_half_tick
);

	adcc_tick_s st_r;
	adcc_tick_s st_nxt;
	logic [6:0] limit;

	// Half period per source; RC modelled from the reference clock
	always_comb begin
		case (i_sel)
			CS_2TOSC:  limit = HALF_2TOSC;
			CS_8TOSC:  limit = HALF_8TOSC;
			CS_32TOSC: limit = HALF_32TOSC;
			CS_RC:     limit = HALF_RC;
			default:   limit = HALF_RC;
		endcase
	end

	// Counter restarts with every conversion so phase is fixed
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (!i_run) begin
			st_nxt.cnt = 7'h00;
		end else if (st_r.cnt == limit - 7'h01) begin
			st_nxt.cnt  = 7'h00;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 7'h01;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_half_tick = st_r.tick;

endmodule
`default_nettype wire

// File: dv/adcc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module adcc_assertions
	import adcc_pkg::*;
(
	input wire logic	i_ref_clk,
	input wire logic	i_rstn,
	input wire logic [7:0]	i_avs_address,
	input wire logic	i_avs_read,
	input wire logic	i_avs_write,
	input wire logic [31:0]	o_avs_readdata,
	input wire logic	o_avs_waitrequest,
	input wire logic [7:0]	o_dac_code,
	input wire logic	o_sample_connect,
	input wire logic	o_power_on,
	input wire adcc_pin_s	o_pin_cfg
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	// Capacitor leaves the pin: a conversion has begun
	sequence conv_start;
		$fell(o_sample_connect);
	endsequence
	// Bus answers one cycle after the request, for one cycle only
	bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer timing");
	ctrl_bit1_a: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address == REG_CTRL0
		|-> !o_avs_readdata[1]) else $error("control bit 1 not zero");
	pcfg_high_a: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address == REG_PCFG
		|-> o_avs_readdata[7:3] == 5'h00) else $error("port config high bits not zero");
	// Trial code starts at the top bit, and only while powered
	start_msb_a: assert property (conv_start |-> o_dac_code == SAR_MSB && o_power_on)
		else $error("bad conversion start");
	conv_min_a: assert property (conv_start |-> !o_sample_connect[*8])
		else $error("conversion too short");
	conv_max_a: assert property (conv_start |-> ##[1:800] o_sample_connect)
		else $error("conversion too long");
	off_dac_a: assert property (!o_power_on && !$past(o_power_on) |-> o_dac_code == 8'h00)
		else $error("trial code while off");
	ref_pins_a: assert property (o_pin_cfg.ext_ref |-> !o_pin_cfg.analog[3]
		&& o_pin_cfg.analog[1:0] == 2'h3) else $error("reference decode");
endmodule
`default_nettype wire

// File: dv/adcc_front_model.sv
`timescale 1ns/100ps
`default_nettype none
module adcc_front_model (
	input wire logic	i_ref_clk,
	input wire logic	i_power_on,
	input wire logic [1:0]	i_channel,
	input wire logic [7:0]	i_dac_code,
	input wire logic [31:0]	i_levels,
	output logic	o_cmp
);
	logic	toggle_r = 1'b0;
	// Unpowered comparator output is junk, so it wanders
	always_ff @(posedge i_ref_clk) begin
		toggle_r <= ~toggle_r;
	end
	// Pin level of the chosen channel against the trial code
	always_comb begin
		o_cmp = i_power_on ? (i_levels[8 * i_channel +: 8] >= i_dac_code) : toggle_r;
	end
endmodule
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import adcc_pkg::*;
	logic	i_ref_clk = 1'b0;
	logic	i_rstn = 1'b0;
	logic [7:0]	i_avs_address = 8'h00;
	logic	i_avs_read = 1'b0;
	logic	i_avs_write = 1'b0;
	logic [31:0]	i_avs_writedata = 32'h0;
	logic [3:0]	i_avs_byteenable = 4'hF;
	logic [31:0]	o_avs_readdata;
	logic	o_avs_waitrequest;
	logic	i_cmp;
	logic [7:0]	o_dac_code;
	logic	o_sample_connect;
	logic	o_power_on;
	logic	o_irq;
	logic [1:0]	o_channel;
	adcc_pin_s	o_pin_cfg;
	logic [31:0]	levels = 32'h5AA5FF00;
	logic [31:0]	q;
	logic [6:0]	h;
	logic [7:0]	c;
	int	cnt;
	int	n_fail = 0;
	int	total_checks = 0;
	// Rows: address, write data, expected read, expected pin decode
	logic [31:0]	rows [13] = '{32'h9F00001E, 32'h9F01010F, 32'h9F02021E, 32'h9F03030F,
		32'h9F040416, 32'h9F050507, 32'h9F060600, 32'h9FFF0700, 32'h1FDAD800,
		32'h1F040000, 32'hA1FF0100, 32'h50FF0000, 32'hA0FF0000};

	always #25 i_ref_clk = ~i_ref_clk;
	adcc_conv_ctrl i_adcc_conv_ctrl (.*);
	adcc_front_model i_adcc_front_model (.i_ref_clk(i_ref_clk), .i_power_on(o_power_on),
		.i_channel(o_channel), .i_dac_code(o_dac_code), .i_levels(levels), .o_cmp(i_cmp));

	task automatic close_out;
		if (n_fail == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int n = 0;
		@(posedge i_ref_clk);
		i_avs_write <= wr;
		i_avs_read <= !wr;
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, d};
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_avs_waitrequest !== 1'b0 && n < 20);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
		if (o_avs_waitrequest !== 1'b0) begin
			n_fail++;
			close_out();
		end
	endtask

	initial begin
		repeat (20) @(posedge i_ref_clk);
		chk("reset outputs", {o_avs_waitrequest, o_sample_connect, o_pin_cfg, o_irq, o_dac_code,
			o_power_on}, {2'h3, 5'h1E, 10'h000});
		i_rstn <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b1, rows[i][31:24], rows[i][23:16]);
			bus(1'b0, rows[i][31:24], 8'h00);
			chk("register", q, {24'h0, rows[i][15:8]});
			chk("pin config", o_pin_cfg, {27'h0, rows[i][4:0]});
		end
		// One conversion per clock source; sel 00 is too fast to trust the result
		bus(1'b1, REG_PCFG, 8'h00);
		for (int i = 0; i < 4; i++) begin
			h = (i == 0) ? HALF_2TOSC : (i == 1) ? HALF_8TOSC : (i == 2) ? HALF_32TOSC : HALF_RC;
			c = {i[1:0], i[2:0], 3'b001};
			bus(1'b1, REG_IRQ_STAT, 8'h01);
			bus(1'b1, REG_CTRL0, c);
			repeat (40) @(posedge i_ref_clk);
			chk("irq cleared", o_irq, 1'b0);
			chk("channel", o_channel, i[1:0]);
			bus(1'b1, REG_CTRL0, c | 8'h04);
			cnt = 0;
			do begin
				@(posedge i_ref_clk);
				cnt++;
			end while (o_sample_connect !== 1'b1 && cnt < 2000);
			if (cnt >= 2000) begin
				n_fail++;
				close_out();
			end
			chk("conv time", cnt >= 19 * h && cnt <= 19 * h + 3, 1'b1);
			bus(1'b0, REG_CTRL0, 8'h00);
			chk("go cleared", q, {24'h0, c});
			bus(1'b0, REG_RESULT, 8'h00);
			if (i != 0) chk("result", q, {24'h0, levels[8 * i +: 8]});
			bus(1'b0, REG_IRQ_STAT, 8'h00);
			chk("done flag", {q[7:0], o_irq}, 9'h003);
			repeat (4 * h) @(posedge i_ref_clk);
		end
		// Second reset must leave the last result in place
		i_rstn <= 1'b0;
		repeat (20) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		bus(1'b0, REG_RESULT, 8'h00);
		chk("result kept", q, {24'h0, levels[31:24]});
		close_out();
	end
endmodule
bind adcc_conv_ctrl adcc_assertions i_adcc_assertions (.*);
`default_nettype wire
